// file: cbk_consts.svh
// Constants of the clock bank strap and lock logic: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CBK_CONSTS_SVH
`define CBK_CONSTS_SVH
`define CBK_NUM_BANKS 8
`define CBK_OFF_STRAP0 32'h0000_0000
`define CBK_OFF_STRAP1 32'h0000_0004
`define CBK_OFF_MODE 32'h0000_0008
`define CBK_OFF_STATUS 32'h0000_000C
`define CBK_OFF_IRQ_STAT 32'h0000_0010
`define CBK_OFF_IRQ_EN 32'h0000_0014
`define CBK_OFF_IRQ_CLR 32'h0000_0018
`define CBK_OFF_LOCKCFG 32'h0000_001C
`define CBK_TRI_LOW 2'h0
`define CBK_TRI_MID 2'h1
`define CBK_TRI_HIGH 2'h2
`define CBK_TRI_OPEN 2'h3
`define CBK_IRQ_LOCK_RISE 0
`define CBK_IRQ_LOCK_FALL 1
`define CBK_IRQ_STRAP_MOVE 2
`define CBK_IRQ_W 3
`define CBK_THR_LOW_RESET 8'h10
`define CBK_THR_MID_RESET 8'h08
`define CBK_THR_HIGH_RESET 8'h04
`define CBK_RANGE_LOW_MIN_MHZ 24
`define CBK_RANGE_LOW_MAX_MHZ 50
`define CBK_RANGE_MID_MIN_MHZ 48
`define CBK_RANGE_MID_MAX_MHZ 100
`define CBK_RANGE_HIGH_MIN_MHZ 96
`define CBK_RANGE_HIGH_MAX_MHZ 200
`endif

// file: cbk_pkg.sv
// Types shared by the clock bank strap and lock logic.
// Assumes the constants header sits in the same folder.
`include "cbk_consts.svh"
package cbk_pkg;
	typedef enum logic [1:0] {
		CBK_LOW = `CBK_TRI_LOW,
		CBK_MID = `CBK_TRI_MID,
		CBK_HIGH = `CBK_TRI_HIGH
	} cbk_tri_t;
	typedef enum logic [2:0] {
		CBK_ST_RUN = 3'h1,
		CBK_ST_RESET = 3'h2,
		CBK_ST_TEST = 3'h4
	} cbk_state_t;
endpackage : cbk_pkg

// file: cbk_bank.sv
// One output bank: divider, inversion, disable levels, phase delay and output gating.
// Assumes sys_clk_i is the PLL clock and all straps are already decoded ternaries.
`timescale 1ns/10ps
`include "cbk_consts.svh"
module cbk_bank #(
	parameter int DIV_W = 5
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Decoded ternary straps, two bits per digit.
	input wire logic [7:0] divide_select_i,
	input wire logic [3:0] phase_select_i,
	// Output control.
	input wire logic lvds_i,
	input wire logic gate_i,
	input wire logic bypass_i,
	input wire logic feedback_clock_i,
	// Output pair.
	output logic q0_o,
	output logic q1_o
);
	initial begin
		if (DIV_W < 2 || DIV_W > 8) $error("cbk_bank: DIV_W out of range");
	end

	// The divide digits fold into a ratio; digit 3 selects inversion or a disable level.
	wire logic [1:0] ds3 = divide_select_i[7:6];
	wire logic dis_low = (ds3 == `CBK_TRI_HIGH) && (divide_select_i[1:0] == `CBK_TRI_HIGH);
	wire logic dis_high = (ds3 == `CBK_TRI_HIGH) && (divide_select_i[1:0] == `CBK_TRI_MID);
	wire logic invert = (ds3 == `CBK_TRI_MID);
	// Products are widened first so that the largest ratio, 26, and delay, 8, survive the sum.
	wire logic [7:0] ratio_full = 8'(divide_select_i[5:4]) * 8'h09
		+ 8'(divide_select_i[3:2]) * 8'h03 + 8'(divide_select_i[1:0]);
	wire logic [DIV_W-1:0] ratio = ratio_full[DIV_W-1:0];
	wire logic [3:0] delay = 4'(phase_select_i[3:2]) * 4'h3 + 4'(phase_select_i[1:0]);

	logic [DIV_W-1:0] count;
	logic div_clk;
	logic [8:0] tap;
	logic gate_q;
	wire logic [DIV_W-1:0] next_count = (count >= ratio) ? '0 : DIV_W'(count + 1'b1);

	// Divider, phase delay line and a gate that only changes with the divided clock low.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= '0;
			div_clk <= 1'b0;
			tap <= '0;
			gate_q <= 1'b1;
		end else begin
			count <= next_count;
			if (next_count == '0) div_clk <= ~div_clk;
			tap <= {tap[7:0], div_clk};
			if (!tap[delay]) gate_q <= gate_i;
		end
	end

	// Gating forces low, but a disabled bank keeps its own level.
	wire logic raw = bypass_i ? feedback_clock_i : (tap[delay] ^ invert);
	wire logic level = dis_low ? 1'b0 : dis_high ? 1'b1 : (gate_q ? 1'b0 : raw);

	// In LVDS the pair is complementary; in LVCMOS both carry the same clock.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q0_o <= 1'b0;
			q1_o <= 1'b0;
		end else begin
			q0_o <= level;
			q1_o <= lvds_i ? ~level : level;
		end
	end

	chk_lvds_pair: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$past(lvds_i) && $past(nrst_i) |-> q1_o == ~q0_o) else $error("pair not complementary");
endmodule : cbk_bank

// file: cbk_top.sv
// Strap decoding, lock flag, interrupts and AHB-Lite registers of the clock bank manager.
// Assumes sys_clk_i is the PLL output and straps are static except while in reset.
//
// Notes on behaviour
// - Signalling strap picks LVCMOS or LVDS per bank.
// - LVDS pair outputs are complements.
// - Four divide digits pick divider, inversion, enable.
// - Two phase digits pick bank phase.
// - Bypass not LOW holds PLL reset.
// - Range strap picks PLL frequency range.
// - Output gate forces enabled banks low, synchronously.
// - In run mode, lock flag high only when PLL locked.
// - Lock threshold depends on selected range.
// - Reset mode drives lock flag high.
// - Test mode: lock high iff all ternaries low.
// - Open ternary inputs read as MID.
`timescale 1ns/10ps
`include "cbk_consts.svh"
module cbk_top #(
	parameter int NUM_BANKS = `CBK_NUM_BANKS,
	parameter int DIV_W = 5
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Ternary straps, two bits each; code 3 means unconnected.
	input wire logic [1:0] signal_standard_select_i,
	input wire logic [1:0] pll_range_select_i,
	input wire logic [1:0] bypass_mode_select_i,
	input wire logic [1:0] reset_divide_i,
	input wire logic [NUM_BANKS*8-1:0] bank_divide_select_i,
	input wire logic [NUM_BANKS*4-1:0] bank_phase_select_i,
	// Two-level inputs and the 8-bit phase error.
	input wire logic sync_output_gate_i,
	input wire logic feedback_clock_input_i,
	input wire logic [7:0] phase_error_i,
	// PLL interface.
	output logic pll_reset_o,
	output logic [2:0] pll_range_o,
	// Clock banks.
	output logic [NUM_BANKS-1:0] bank_output_pair0_o,
	output logic [NUM_BANKS-1:0] bank_output_pair1_o,
	output logic [NUM_BANKS-1:0] bank_lvds_o,
	// Status.
	output logic lock_o,
	output logic irq_o,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	initial begin
		if (NUM_BANKS != 8) $error("cbk_top: the signalling map serves exactly 8 banks");
	end

	localparam int NT = 4 + NUM_BANKS * 6;

	// Open inputs fold to MID; every ternary is gathered in one vector.
	wire logic [2*NT-1:0] tri_raw = {bank_phase_select_i, bank_divide_select_i,
		reset_divide_i, bypass_mode_select_i, pll_range_select_i, signal_standard_select_i};
	logic [2*NT-1:0] tri_dec;
	logic all_low;
	always_comb begin
		all_low = 1'b1;
		for (int i = 0; i < NT; i++) begin
			tri_dec[2*i +: 2] = (tri_raw[2*i +: 2] == `CBK_TRI_OPEN) ? `CBK_TRI_MID
				: tri_raw[2*i +: 2];
			if (tri_dec[2*i +: 2] != `CBK_TRI_LOW) all_low = 1'b0;
		end
	end
	wire logic [1:0] std_sel = tri_dec[1:0];
	wire logic [1:0] rng_sel = tri_dec[3:2];
	wire logic [1:0] byp_sel = tri_dec[5:4];
	wire logic [1:0] rst_sel = tri_dec[7:6];
	wire logic [NUM_BANKS*8-1:0] ds_dec = tri_dec[8 +: NUM_BANKS*8];
	wire logic [NUM_BANKS*4-1:0] ps_dec = tri_dec[8+NUM_BANKS*8 +: NUM_BANKS*4];

	// Mode decode: test mode whenever bypass is not LOW, reset mode on reset strap LOW.
	wire logic test_mode = (byp_sel != `CBK_TRI_LOW);
	wire logic reset_mode = !test_mode && (rst_sel == `CBK_TRI_LOW);
	wire cbk_pkg::cbk_state_t mode = test_mode ? cbk_pkg::CBK_ST_TEST
		: reset_mode ? cbk_pkg::CBK_ST_RESET : cbk_pkg::CBK_ST_RUN;
	wire logic bypass_fb = (byp_sel == `CBK_TRI_HIGH);
	assign pll_reset_o = test_mode;

	// Range decode, one-hot LOW/MID/HIGH.
	assign pll_range_o = (rng_sel == `CBK_TRI_LOW) ? 3'h1
		: (rng_sel == `CBK_TRI_MID) ? 3'h2 : 3'h4;

	// Even banks turn LVDS on MID, all banks on HIGH.
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			assign bank_lvds_o[b] = (std_sel == `CBK_TRI_HIGH)
				|| ((std_sel == `CBK_TRI_MID) && (b % 2 == 0));
			cbk_bank #(.DIV_W(DIV_W)) u_bank (
				.sys_clk_i(sys_clk_i),
				.nrst_i(nrst_i),
				.divide_select_i(ds_dec[8*b +: 8]),
				.phase_select_i(ps_dec[4*b +: 4]),
				.lvds_i(bank_lvds_o[b]),
				.gate_i(sync_output_gate_i),
				.bypass_i(bypass_fb),
				.feedback_clock_i(feedback_clock_input_i),
				.q0_o(bank_output_pair0_o[b]),
				.q1_o(bank_output_pair1_o[b])
			);
		end
	endgenerate

	// Registers written by software, plus the PLL-lock and strap samples.
	logic [7:0] thr_low;
	logic [7:0] thr_mid;
	logic [7:0] thr_high;
	logic [`CBK_IRQ_W-1:0] irq_stat;
	logic [`CBK_IRQ_W-1:0] irq_en;
	logic pll_lock;
	logic [2*NT-1:0] strap_q;

	// Threshold follows the range; the phase detector compares within it.
	wire logic [7:0] thr_sel = (rng_sel == `CBK_TRI_LOW) ? thr_low
		: (rng_sel == `CBK_TRI_MID) ? thr_mid : thr_high;
	wire logic aligned = (phase_error_i <= thr_sel);
	wire logic next_lock = test_mode ? all_low
		: reset_mode ? 1'b1
		: aligned;

	// Lock flag and PLL-lock tracking are registered for a clean output.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lock_o <= 1'b0;
			pll_lock <= 1'b0;
			strap_q <= '0;
		end else begin
			lock_o <= next_lock;
			pll_lock <= aligned;
			strap_q <= tri_dec;
		end
	end

	// Events: lock rise, lock fall, straps moving in run mode (not in reset or test mode).
	wire logic strap_move = (strap_q != tri_dec) && !test_mode && !reset_mode;
	wire logic [`CBK_IRQ_W-1:0] irq_evt = {strap_move, pll_lock & ~aligned, ~pll_lock & aligned};

	// AHB-Lite address phase capture; zero wait states.
	logic dph_valid;
	logic dph_write;
	logic [7:0] dph_addr;
	wire logic req = hsel_i && htrans_i[1] && hready_i;
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr <= 8'h00;
		end else begin
			dph_valid <= req;
			dph_write <= hwrite_i;
			dph_addr <= haddr_i[7:0];
		end
	end
	wire logic wr = dph_valid && dph_write;
	wire logic wr_cfg = wr && (32'(dph_addr) == `CBK_OFF_LOCKCFG);
	wire logic wr_en = wr && (32'(dph_addr) == `CBK_OFF_IRQ_EN);
	wire logic wr_clr = wr && (32'(dph_addr) == `CBK_OFF_IRQ_CLR);
	wire logic [`CBK_IRQ_W-1:0] clr_bits = wr_clr ? hwdata_i[`CBK_IRQ_W-1:0] : '0;

	// Register updates; a new event wins over a clear in the same cycle.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			thr_low <= `CBK_THR_LOW_RESET;
			thr_mid <= `CBK_THR_MID_RESET;
			thr_high <= `CBK_THR_HIGH_RESET;
			irq_en <= '0;
			irq_stat <= '0;
		end else begin
			if (wr_cfg) begin
				thr_low <= hwdata_i[7:0];
				thr_mid <= hwdata_i[15:8];
				thr_high <= hwdata_i[23:16];
			end
			if (wr_en) irq_en <= hwdata_i[`CBK_IRQ_W-1:0];
			irq_stat <= (irq_stat & ~clr_bits) | irq_evt;
		end
	end
	assign irq_o = |(irq_stat & irq_en);

	// Read mux; unmapped addresses read zero.
	wire logic [31:0] rd_mux =
		(32'(dph_addr) == `CBK_OFF_STRAP0) ? tri_dec[31:0]
		: (32'(dph_addr) == `CBK_OFF_STRAP1) ? tri_dec[63:32]
		: (32'(dph_addr) == `CBK_OFF_MODE) ? {16'h0000, ps_dec == '0,
			bank_lvds_o, pll_range_o, 1'b0, mode}
		: (32'(dph_addr) == `CBK_OFF_STATUS) ? {29'h0, pll_reset_o, pll_lock, lock_o}
		: (32'(dph_addr) == `CBK_OFF_IRQ_STAT) ? {29'h0, irq_stat}
		: (32'(dph_addr) == `CBK_OFF_IRQ_EN) ? {29'h0, irq_en}
		: (32'(dph_addr) == `CBK_OFF_LOCKCFG) ? {8'h00, thr_high, thr_mid, thr_low}
		: 32'h0000_0000;
	assign hrdata_o = (dph_valid && !dph_write) ? rd_mux : 32'h0000_0000;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	chk_reset_lock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		reset_mode |=> lock_o) else $error("lock low in reset mode");
	chk_test_lock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		test_mode |=> lock_o == $past(all_low)) else $error("test lock wrong");
	chk_run_lock: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		!test_mode && !reset_mode && phase_error_i > thr_sel |=> !lock_o)
		else $error("lock high while misaligned");
	chk_pll_reset: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		pll_reset_o == (byp_sel != `CBK_TRI_LOW)) else $error("pll reset wrong");
	chk_lvds_map: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		std_sel == `CBK_TRI_MID |-> bank_lvds_o == 8'h55) else $error("mid map wrong");
	chk_open_mid: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		signal_standard_select_i == `CBK_TRI_OPEN |-> std_sel == `CBK_TRI_MID)
		else $error("open not mid");
	chk_range_map: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		$onehot(pll_range_o)) else $error("range not one-hot");
	chk_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		irq_evt[0] |=> irq_stat[0]) else $error("event lost");
	cov_reset_mode: cover property (@(posedge sys_clk_i) reset_mode ##1 lock_o);
	cov_test_mode: cover property (@(posedge sys_clk_i) test_mode && all_low);
	cov_lock_rise: cover property (@(posedge sys_clk_i) !lock_o ##1 lock_o);
endmodule : cbk_top

// file: cbk_clk_sink.sv
// Downstream clock receiver model: checks each bank pair and counts rises of bank 0.
// Assumes it shares the PLL clock that also drives the bank registers.
`timescale 1ns/10ps
module cbk_clk_sink (
	// Clock, reset and count clear.
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clr_i,
	// Bank pairs and the signalling map.
	input wire logic [7:0] q0_i,
	input wire logic [7:0] q1_i,
	input wire logic [7:0] lvds_i,
	// Counts seen since the last clear.
	output int bad_pair_o,
	output int rise0_o
);
	logic [7:0] want_q1;
	logic last_q0;
	// An LVDS receiver needs a true complement; LVCMOS pins carry the same clock.
	assign want_q1 = q0_i ^ lvds_i;
	// Sampling once a cycle is enough, since banks change only on the PLL clock.
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bad_pair_o <= 0;
			rise0_o <= 0;
			last_q0 <= 1'b0;
		end else if (clr_i) begin
			bad_pair_o <= 0;
			rise0_o <= 0;
			last_q0 <= q0_i[0];
		end else begin
			bad_pair_o <= bad_pair_o + int'(q1_i !== want_q1);
			rise0_o <= rise0_o + int'(q0_i[0] && !last_q0);
			last_q0 <= q0_i[0];
		end
	end
endmodule : cbk_clk_sink

// file: tb_clock_bank_strap_and_lock_logic.sv
// Self-checking bench for the strap, lock and register logic of the clock bank manager.
// Assumes zero-wait AHB-Lite and a single 25 MHz clock.
`timescale 1ns/10ps
`include "cbk_consts.svh"
module tb_clock_bank_strap_and_lock_logic;
	logic sys_clk_i, nrst_i, gate, clr, hsel, hwrite, hready, hresp, pll_rst, lock, irq;
	logic [1:0] std, rng, byp, rdv, htrans;
	logic [63:0] div;
	logic [7:0] perr, q0, q1, lvds;
	logic [2:0] prange;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int err_total, num_checks, bad_pair, rise0;
	cbk_top i_cbk_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.signal_standard_select_i(std), .pll_range_select_i(rng),
		.bypass_mode_select_i(byp), .reset_divide_i(rdv), .bank_divide_select_i(div),
		.bank_phase_select_i(32'h0000_0000), .sync_output_gate_i(gate),
		.feedback_clock_input_i(1'b0), .phase_error_i(perr), .pll_reset_o(pll_rst),
		.pll_range_o(prange), .bank_output_pair0_o(q0), .bank_output_pair1_o(q1),
		.bank_lvds_o(lvds), .lock_o(lock), .irq_o(irq), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
	cbk_clk_sink i_cbk_clk_sink (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .clr_i(clr),
		.q0_i(q0), .q1_i(q1), .lvds_i(lvds), .bad_pair_o(bad_pair), .rise0_o(rise0));
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : step
	// One single transfer; the request holds until hready is seen high at an edge.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		// Ready and read data are looked at mid-cycle, so the edge that ends a phase is never raced.
		@(negedge sys_clk_i);
		while (hready !== 1'b1) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(negedge sys_clk_i);
		while (hready !== 1'b1) @(negedge sys_clk_i);
		rd = hrdata;
		@(posedge sys_clk_i);
	endtask : bus
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#(40 * 4000);
		err_total++;
		close_out();
	end
	initial begin
		logic [7:0] lv_tab[4] = '{8'h00, 8'h55, 8'hFF, 8'h55};
		logic [2:0] rg_tab[4] = '{3'h1, 3'h2, 3'h4, 3'h2};
		logic [7:0] thr_tab[3] = '{8'h10, 8'h08, 8'h04};
		int rise_tab[3] = '{12, 6, 4};
		{nrst_i, gate, clr, hsel, hwrite, htrans, haddr, hwdata} = '0;
		{std, rng, div, perr} = '0;
		err_total = 0;
		num_checks = 0;
		byp = `CBK_TRI_MID;
		rdv = `CBK_TRI_HIGH;
		step(2);
		nrst_i <= 1'b1;
		// Straps move in test mode, where the PLL is held in reset; the reset strap is raised once from reset mode.
		for (int t = 0; t < 4; t++) begin
			std <= t[1:0];
			rng <= t[1:0];
			step(3);
			chk(lvds, lv_tab[t]);
			chk(prange, rg_tab[t]);
			if (t != 0) chk(lock, 1'b0);
		end
		{std, rng, perr, rdv} <= {4'h0, 8'hFF, `CBK_TRI_LOW};
		for (int t = 3; t >= 0; t--) begin
			byp <= t[1:0];
			step(3);
			chk(pll_rst, t != 0);
		end
		chk(lock, 1'b1);
		$display("test straps done");
		rdv <= `CBK_TRI_HIGH;
		for (int r = 0; r < 3; r++) begin
			byp <= `CBK_TRI_MID;
			rng <= r[1:0];
			step(2);
			byp <= `CBK_TRI_LOW;
			perr <= thr_tab[r];
			step(3);
			chk(lock, 1'b1);
			perr <= thr_tab[r] + 8'h01;
			step(3);
			chk(lock, 1'b0);
		end
		$display("test lock done");
		bus(1'b0, `CBK_OFF_LOCKCFG, 32'h0);
		chk(rd, 32'h0004_0810);
		bus(1'b1, `CBK_OFF_LOCKCFG, 32'h0004_0820);
		bus(1'b0, `CBK_OFF_LOCKCFG, 32'h0);
		chk(rd, 32'h0004_0820);
		bus(1'b0, 32'h0000_0040, 32'h0);
		chk(rd, 32'h0);
		perr <= 8'h00;
		step(3);
		bus(1'b1, `CBK_OFF_IRQ_EN, 32'h1);
		step(1);
		chk(irq, 1'b1);
		bus(1'b1, `CBK_OFF_IRQ_EN, 32'h0);
		step(1);
		chk(irq, 1'b0);
		bus(1'b1, `CBK_OFF_IRQ_EN, 32'h1);
		bus(1'b1, `CBK_OFF_IRQ_CLR, 32'h1);
		step(1);
		chk(irq, 1'b0);
		bus(1'b0, `CBK_OFF_IRQ_STAT, 32'h0);
		chk(rd & 32'h1, 32'h0);
		$display("test registers done");
		byp <= `CBK_TRI_MID;
		for (int d = 0; d < 3; d++) begin
			div <= {56'h0, 6'h0, d[1:0]};
			step(6);
			clr <= 1'b1;
			step(1);
			clr <= 1'b0;
			step(24);
			chk(rise0 inside {[rise_tab[d] - 1 : rise_tab[d] + 1]}, 1'b1);
			chk(bad_pair, 0);
		end
		// Bank 1 is disabled high, so the gate must leave it alone.
		{std, div} <= {`CBK_TRI_HIGH, 64'h0000_0000_0000_8100};
		gate <= 1'b1;
		step(10);
		clr <= 1'b1;
		step(1);
		clr <= 1'b0;
		step(16);
		chk(rise0, 0);
		chk(q0[1:0], 2'h2);
		chk(bad_pair, 0);
		gate <= 1'b0;
		step(16);
		chk(rise0 != 0, 1'b1);
		$display("test banks done");
		close_out();
	end
endmodule : tb_clock_bank_strap_and_lock_logic
